// ==== shared/i2c_target_pkg.sv ====
package i2c_target_pkg;

  // Four-level strap pin codes
  localparam logic [1:0] LEVEL_LOW   = 2'h0;
  localparam logic [1:0] LEVEL_RES   = 2'h1;
  localparam logic [1:0] LEVEL_FLOAT = 2'h2;
  localparam logic [1:0] LEVEL_HIGH  = 2'h3;

  // Target address base, chosen by the high select pin
  localparam logic [6:0] BASE_HI_LOW   = 7'h44;
  localparam logic [6:0] BASE_HI_RES   = 7'h20;
  localparam logic [6:0] BASE_HI_FLOAT = 7'h10;
  localparam logic [6:0] BASE_HI_HIGH  = 7'h0C;

  // Pointer and bit encodings
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic       RW_WRITE  = 1'b0;
  localparam logic       RW_READ   = 1'b1;
  localparam logic       ACK_BIT   = 1'b0;
  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam logic [3:0] ACK_SLOT  = 4'h8;

  // Strap settle count after reset release
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // Controller timing
  localparam int CLK_PERIOD_NS      = 20;
  localparam int SCL_PERIOD_NS      = 10000;
  localparam int SCL_QUARTER_CYCLES =
    (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // Transactions the controller can run
  typedef enum logic [1:0] {op_write, op_read_combined, op_read_plain} op_type;

  // Strap levels to 7-bit target address
  function automatic logic [6:0] target_address(input logic [1:0] hi,
                                                input logic [1:0] lo);
    logic [6:0] base;
    unique case (hi)
      LEVEL_LOW:   base = BASE_HI_LOW;
      LEVEL_RES:   base = BASE_HI_RES;
      LEVEL_FLOAT: base = BASE_HI_FLOAT;
      default:     base = BASE_HI_HIGH;
    endcase
    return base | {5'h00, lo};
  endfunction

endpackage

// ==== shared/i2c_link_if.sv ====
`timescale 1ns/1ps
interface i2c_link_if;
  // Clock line, driven by the controller only
  logic scl;
  // Open-drain data line, one driver pair per end
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  // Resolved wired-and level
  logic sda;

  // Released line floats high through the pull-up
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport controller (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport target     (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

// ==== hw/i2c_register_target.sv ====
// Behaviour
// - Controller writes: START, address, direction zero
// - Acknowledge an address byte that matches
// - Controller sends one offset byte, MSB first
// - Acknowledge offset, load register pointer
// - Store and acknowledge every data byte
// - Controller ends each write with STOP
// - Offset-less read starts at current pointer
// - Read after write starts at written offset
// - Release data, sample controller acknowledge
// - Controller acknowledges bytes it wants continued
// - Ack sends next byte; nack waits STOP
// - Combined read uses repeated START, no STOP
// - Resend address with direction one
// - Combined read acks, sends from offset
// - Offset-only write sets pointer, writes nothing
// - Pointer is zero after power-up
// - Pointer increments per read byte always
// - Access only documented register offsets; target accepts any 8-bit offset
// - Address from two four-level strap pins
`timescale 1ns/1ps
module i2c_register_target
  import i2c_target_pkg::*;
(
  // Link sampling clock and power-good reset
  input  wire logic       link_clk,
  input  wire logic       link_rst,
  // Address strap levels
  input  wire logic [1:0] address_select_high_pin,
  input  wire logic [1:0] shared_eq_address_low_pin,
  // Bus pins
  i2c_link_if.target      link,
  // Register file write port
  output logic            reg_wr_valid,
  output logic [7:0]      reg_wr_addr,
  output logic [7:0]      reg_wr_data,
  // Register file read port
  output logic [7:0]      reg_rd_addr,
  input  wire logic [7:0] reg_rd_data,
  // Latched target address
  output logic [6:0]      own_address
);

  // Protocol phases
  typedef enum logic [2:0] {
    t_idle,
    t_rx,
    t_rx_ack,
    t_tx,
    t_tx_ack,
    t_ignore
  } tstate_type;

  // What the next received byte means
  typedef enum logic [1:0] {k_addr, k_offs, k_data} kind_type;

  // Whole state of the target
  typedef struct packed {
    logic       scl_s1;      // Clock sync, first stage
    logic       scl_s2;      // Clock sync, second stage
    logic       scl_q;       // Delayed clock for edges
    logic       sda_s1;      // Data sync, first stage
    logic       sda_s2;      // Data sync, second stage
    logic       sda_q;       // Delayed data for edges
    logic [1:0] hi_s1;       // High strap sync
    logic [1:0] hi_s2;
    logic [1:0] lo_s1;       // Low strap sync
    logic [1:0] lo_s2;
    logic [1:0] strap_age;   // Cycles since reset release
    logic [6:0] own_addr;    // Captured target address
    tstate_type st;          // Protocol phase
    kind_type   kind;        // Meaning of current byte
    logic       rw;          // Direction of last address
    logic [2:0] cnt;         // Bit index in byte
    logic       byte_done;   // Byte complete or ack seen
    logic [7:0] sh;          // Shift register
    logic [7:0] ptr;         // Read pointer
    logic [7:0] wptr;        // Write pointer
    logic       sda_oe;      // Pulling data low
    logic       drv_o;       // Driven level, always low
    logic       wr_valid;    // Write strobe
    logic [7:0] wr_addr;     // Write address
    logic [7:0] wr_data;     // Write data
  } state_type;

  state_type r;              // Registered state
  state_type n;              // Next state
  logic      scl_rise;       // Clock rising edge
  logic      scl_fall;       // Clock falling edge
  logic      start_seen;     // START or repeated START
  logic      stop_seen;      // STOP

  // Bus events from the synchronised lines only
  assign scl_rise   = r.scl_s2 & ~r.scl_q;
  assign scl_fall   = ~r.scl_s2 & r.scl_q;
  assign start_seen = r.scl_s2 & r.scl_q & r.sda_q & ~r.sda_s2;
  assign stop_seen  = r.scl_s2 & r.scl_q & ~r.sda_q & r.sda_s2;

  // Next-state logic
  always_comb begin
    n = r;
    // Two-stage synchronisers, then an edge stage
    n.scl_s1   = link.scl;
    n.scl_s2   = r.scl_s1;
    n.scl_q    = r.scl_s2;
    n.sda_s1   = link.sda;
    n.sda_s2   = r.sda_s1;
    n.sda_q    = r.sda_s2;
    n.hi_s1    = address_select_high_pin;
    n.hi_s2    = r.hi_s1;
    n.lo_s1    = shared_eq_address_low_pin;
    n.lo_s2    = r.lo_s1;
    n.wr_valid = 1'b0;
    n.drv_o    = 1'b0;

    // Straps caught once the synchronisers hold pin values
    if (r.strap_age != LEVEL_HIGH) begin
      n.strap_age = r.strap_age + 2'h1;
    end
    if (r.strap_age == STRAP_SETTLE) begin
      n.own_addr = target_address(r.hi_s2, r.lo_s2);
    end

    if (start_seen) begin
      // START from any phase; pointer survives a repeated START
      n.st        = t_rx;
      n.kind      = k_addr;
      n.cnt       = 3'h0;
      n.byte_done = 1'b0;
      n.sda_oe    = 1'b0;
    end else if (stop_seen) begin
      // STOP ends everything and frees the line
      n.st     = t_idle;
      n.sda_oe = 1'b0;
    end else begin
      unique case (r.st)
        t_idle, t_ignore: begin
          n.sda_oe = 1'b0;
        end
        t_rx: begin
          if (scl_rise) begin
            // Sample while clock is high
            n.sh  = {r.sh[6:0], r.sda_s2};
            n.cnt = r.cnt + 3'h1;
            if (r.cnt == LAST_BIT) begin
              n.byte_done = 1'b1;
            end
          end else if (scl_fall && r.byte_done) begin
            // Decide on the byte once clock is low again
            n.byte_done = 1'b0;
            n.st        = t_rx_ack;
            n.sda_oe    = 1'b1;
            unique case (r.kind)
              k_addr: begin
                if (r.sh[7:1] == r.own_addr) begin
                  n.rw   = r.sh[0];
                  n.kind = k_offs;
                end else begin
                  n.st     = t_ignore;
                  n.sda_oe = 1'b0;
                end
              end
              k_offs: begin
                n.ptr  = r.sh;
                n.wptr = r.sh;
                n.kind = k_data;
              end
              k_data: begin
                n.wr_valid = 1'b1;
                n.wr_addr  = r.wptr;
                n.wr_data  = r.sh;
                n.wptr     = r.wptr + 8'h01;
              end
              default: begin
                // Illegal code, drop the transfer
                n.st     = t_ignore;
                n.sda_oe = 1'b0;
              end
            endcase
          end
        end
        t_rx_ack: begin
          if (scl_fall) begin
            n.cnt = 3'h0;
            if (r.rw == RW_READ) begin
              // first bit out as ack ends
              n.st     = t_tx;
              n.sh     = reg_rd_data;
              n.sda_oe = ~reg_rd_data[7];
            end else begin
              // offset alone never strobes a write
              n.st     = t_rx;
              n.sda_oe = 1'b0;
            end
          end
        end
        t_tx: begin
          if (scl_fall) begin
            if (r.cnt == LAST_BIT) begin
              n.sda_oe    = 1'b0;
              n.st        = t_tx_ack;
              n.byte_done = 1'b0;
              n.ptr       = r.ptr + 8'h01;
            end else begin
              // Next bit, MSB first
              n.cnt    = r.cnt + 3'h1;
              n.sh     = {r.sh[6:0], 1'b0};
              n.sda_oe = ~r.sh[6];
            end
          end
        end
        t_tx_ack: begin
          if (scl_rise) begin
            n.byte_done = (r.sda_s2 == ACK_BIT);
          end else if (scl_fall) begin
            if (r.byte_done) begin
              n.st        = t_tx;
              n.cnt       = 3'h0;
              n.sh        = reg_rd_data;
              n.sda_oe    = ~reg_rd_data[7];
              n.byte_done = 1'b0;
            end else begin
              n.st = t_ignore;
            end
          end
        end
        default: begin
          // Unused phase codes recover to idle
          n.st     = t_idle;
          n.sda_oe = 1'b0;
        end
      endcase
    end

    // Power-good reset; straps are recaptured after it
    if (link_rst) begin
      n = '0;
      n.st = t_idle;
      n.ptr  = PTR_RESET;
      n.wptr = PTR_RESET;
    end
  end

  // State register
  always_ff @(posedge link_clk) begin
    r <= n;
  end

  // Pins and register ports, all from flops
  assign link.dev_sda_o  = r.drv_o;
  assign link.dev_sda_oe = r.sda_oe;
  assign reg_wr_valid    = r.wr_valid;
  assign reg_wr_addr     = r.wr_addr;
  assign reg_wr_data     = r.wr_data;
  assign reg_rd_addr     = r.ptr;
  assign own_address     = r.own_addr;

endmodule

// ==== hw/i2c_register_controller.sv ====
`timescale 1ns/1ps
module i2c_register_controller
  import i2c_target_pkg::*;
#(
  parameter int QUARTER = SCL_QUARTER_CYCLES
)(
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Bus pins
  i2c_link_if.controller  link,
  // Transaction request
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire op_type     cmd_op,
  input  wire logic [6:0] cmd_addr,
  input  wire logic [7:0] cmd_offset,
  input  wire logic [7:0] cmd_len,
  // Write data stream
  input  wire logic       wr_valid,
  output logic            wr_ready,
  input  wire logic [7:0] wr_data,
  // Read data and completion
  output logic            rd_valid,
  output logic [7:0]      rd_data,
  output logic            done,
  output logic            nack_err
);

  localparam int QW = $clog2(QUARTER + 1);

  // Bit-cell kinds the sequencer runs
  typedef enum logic [2:0] {h_idle, h_start, h_byte, h_fetch, h_stop} hstate_type;

  // Position within a transaction
  typedef enum logic [2:0] {s_addr, s_offs, s_wdata, s_raddr, s_rdata} step_type;

  // Whole state of the controller
  typedef struct packed {
    logic          sda_s1;    // Data sync, first stage
    logic          sda_s2;    // Data sync, second stage
    hstate_type    st;        // Current cell kind
    step_type      step;      // Current byte role
    op_type        op;        // Captured operation
    logic [6:0]    addr;      // Captured target address
    logic [7:0]    offs;      // Captured offset
    logic [7:0]    remain;    // Data bytes left
    logic [QW-1:0] qcnt;      // Quarter-period divider
    logic [1:0]    q;         // Quarter within a cell
    logic [3:0]    bitn;      // Bit slot within a byte
    logic [7:0]    tx;        // Transmit shifter
    logic [7:0]    rx;        // Receive shifter
    logic          samp;      // Level sampled mid-high
    logic          scl_o;     // Clock line
    logic          sda_o;     // Driven level, always low
    logic          sda_oe;    // Pulling data low
    logic          cmd_ready; // Ready for a request
    logic          wr_ready;  // Ready for a data byte
    logic          rd_valid;  // Read byte strobe
    logic [7:0]    rd_data;   // Read byte
    logic          done;      // Transaction finished
    logic          nack_err;  // Target refused a byte
  } state_type;

  state_type r;               // Registered state
  state_type n;               // Next state
  logic      tick;            // End of a quarter
  logic      bitval;          // Data level in this slot
  logic [1:0] lines;          // Clock and data for this quarter

  // Line levels per cell and quarter, {scl, sda}
  function automatic logic [1:0] cell_lines(input hstate_type st, input logic [1:0] q,
                                            input logic bv);
    unique case (st)
      h_start: cell_lines = {q[0] ^ q[1], ~q[1]};
      h_byte:  cell_lines = {q[0] ^ q[1], bv};
      h_stop:  cell_lines = {q != 2'h0, q[1]};
      h_fetch: cell_lines = 2'b01;
      default: cell_lines = 2'b11;
    endcase
  endfunction

  assign tick = (r.qcnt == QW'(QUARTER - 1));

  // Slot level: address, offset, data, or the acknowledge
  always_comb begin
    bitval = 1'b1;
    if (r.bitn != ACK_SLOT) begin
      bitval = (r.step == s_rdata) ? 1'b1 : r.tx[7];
    end else if (r.step == s_rdata) begin
      // ack all but the last byte
      bitval = (r.remain == 8'h01);
    end
    lines = cell_lines(r.st, r.q, bitval);
  end

  // Next-state logic
  always_comb begin
    n = r;
    n.sda_s1   = link.sda;
    n.sda_s2   = r.sda_s1;
    n.rd_valid = 1'b0;
    n.done     = 1'b0;
    n.sda_o    = 1'b0;
    n.scl_o    = lines[1];
    n.sda_oe   = ~lines[0];
    unique case (r.st)
      h_idle: begin
        n.cmd_ready = 1'b1;
        if (cmd_valid && r.cmd_ready) begin
          n.cmd_ready = 1'b0;
          n.op        = cmd_op;
          n.addr      = cmd_addr;
          n.offs      = cmd_offset;
          n.remain    = (cmd_op != op_write && cmd_len == 8'h00) ? 8'h01 : cmd_len;
          n.nack_err  = 1'b0;
          n.step      = s_addr;
          n.st        = h_start;
          n.q         = 2'h0;
          n.qcnt      = '0;
        end
      end
      h_fetch: begin
        // Clock held low until the next byte arrives
        if (wr_valid && r.wr_ready) begin
          n.tx       = wr_data;
          n.wr_ready = 1'b0;
          n.st       = h_byte;
          n.bitn     = 4'h0;
          n.q        = 2'h0;
          n.qcnt     = '0;
        end
      end
      h_start, h_byte, h_stop: begin
        n.qcnt = tick ? '0 : r.qcnt + QW'(1);
        if (tick) begin
          n.q = r.q + 2'h1;
          if (r.q == 2'h1) begin
            n.samp = r.sda_s2;
          end
          if (r.q == 2'h3) begin
            unique case (r.st)
              h_start: begin
                n.st   = h_byte;
                n.bitn = 4'h0;
                n.tx   = {r.addr, (r.step == s_raddr || r.op == op_read_plain) ?
                          RW_READ : RW_WRITE};
              end
              h_stop: begin
                n.st   = h_idle;
                n.done = 1'b1;
              end
              default: begin
                if (r.bitn != ACK_SLOT) begin
                  n.bitn = r.bitn + 4'h1;
                  n.tx   = {r.tx[6:0], 1'b0};
                  n.rx   = {r.rx[6:0], r.samp};
                end else if (r.step == s_rdata) begin
                  n.rd_valid = 1'b1;
                  n.rd_data  = r.rx;
                  n.remain   = r.remain - 8'h01;
                  n.bitn     = 4'h0;
                  if (r.remain == 8'h01) begin
                    n.st = h_stop;
                  end
                end else if (r.samp != ACK_BIT) begin
                  n.nack_err = 1'b1;
                  n.st       = h_stop;
                end else begin
                  n.bitn = 4'h0;
                  unique case (r.step)
                    s_addr: begin
                      n.step = (r.op == op_read_plain) ? s_rdata : s_offs;
                      n.tx   = r.offs;
                    end
                    s_offs: begin
                      if (r.op == op_read_combined) begin
                        n.step = s_raddr;
                        n.st   = h_start;
                      end else if (r.remain == 8'h00) begin
                        n.st = h_stop;
                      end else begin
                        n.step     = s_wdata;
                        n.st       = h_fetch;
                        n.wr_ready = 1'b1;
                      end
                    end
                    s_wdata: begin
                      n.remain = r.remain - 8'h01;
                      if (r.remain == 8'h01) begin
                        n.st = h_stop;
                      end else begin
                        n.st       = h_fetch;
                        n.wr_ready = 1'b1;
                      end
                    end
                    default: n.step = s_rdata;
                  endcase
                end
              end
            endcase
          end
        end
      end
      default: n.st = h_idle;
    endcase
    // Reset leaves both lines released
    if (rst) begin
      n = '0;
      n.scl_o = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    r <= n;
  end

  // Pins and user ports, all from flops
  assign link.scl         = r.scl_o;
  assign link.host_sda_o  = r.sda_o;
  assign link.host_sda_oe = r.sda_oe;
  assign cmd_ready        = r.cmd_ready;
  assign wr_ready         = r.wr_ready;
  assign rd_valid         = r.rd_valid;
  assign rd_data          = r.rd_data;
  assign done             = r.done;
  assign nack_err         = r.nack_err;

endmodule

// ==== test/i2c_register_target_monitor.sv ====
`timescale 1ns/1ps
module i2c_register_target_monitor (
  // Target domain clock and reset
  input wire logic link_clk,
  input wire logic link_rst,
  // Bus signals
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  default clocking mon_cb @(posedge link_clk);
  endclocking
  default disable iff (link_rst);

  // Length of the current target drive
  logic [10:0] drive_cnt_reg;
  logic [10:0] drive_cnt_next;

  // Restart the count whenever the target lets go
  always_comb begin
    drive_cnt_next = dev_sda_oe ? drive_cnt_reg + 11'h001 : 11'h000;
  end

  // Count register
  always_ff @(posedge link_clk) begin
    drive_cnt_reg <= link_rst ? 11'h000 : drive_cnt_next;
  end

  // Open drain: either end may only pull low
  chk_host_pull_low: assert property (host_sda_oe |-> !host_sda_o)
    else $error("controller drives data high");
  chk_dev_pull_low: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("target drives data high");
  chk_dev_stable_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("target data changed while clock high");
  chk_dev_rise_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("target pull began while clock high");
  chk_dev_fall_low: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("target release while clock high");
  // An acknowledge followed by a byte of zeros is the longest legal pull; longer means a stuck target
  chk_dev_release_bound: assert property (drive_cnt_reg < 11'd1000)
    else $error("target held data low too long");
  chk_stop_released: assert property (scl && $past(scl) && $rose(sda) |-> !dev_sda_oe)
    else $error("target driving at stop");
  chk_reset_quiet: assert property (disable iff (1'b0) link_rst |=> !dev_sda_oe)
    else $error("target drives data in reset");
endmodule

// ==== test/i2c_register_target_tb_top.sv ====
`timescale 1ns/1ps
module i2c_register_target_tb_top;
  import i2c_target_pkg::*;
  // Shortened quarter cell for simulation
  localparam int QTR = 8;
  // Clocks, resets and ports
  logic       clk, rst, link_clk, link_rst;
  logic       cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, done, nack_err;
  op_type     cmd_op;
  logic [6:0] cmd_addr, own_address;
  logic [7:0] cmd_offset, cmd_len, wr_data, rd_data;
  logic       reg_wr_valid;
  logic [7:0] reg_wr_addr, reg_wr_data, reg_rd_addr, reg_rd_data;
  logic [1:0] strap_high, strap_low;
  // Register model, expectations and logs
  logic [7:0]  mem [256];
  logic [7:0]  exp_mem [256];
  logic [7:0]  rq[$], wq[$];
  logic [15:0] wlog[$];
  int          failures, cmp_count;

  i2c_link_if link_if ();
  i2c_register_controller #(.QUARTER(QTR)) i2c_register_controller_i (
    .clk(clk), .rst(rst), .link(link_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_offset(cmd_offset), .cmd_len(cmd_len),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .done(done), .nack_err(nack_err));
  // Straps start floating, one scenario moves them
  i2c_register_target i2c_register_target_i (
    .link_clk(link_clk), .link_rst(link_rst), .address_select_high_pin(strap_high),
    .shared_eq_address_low_pin(strap_low), .link(link_if), .reg_wr_valid(reg_wr_valid),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data), .own_address(own_address));
  i2c_register_target_monitor i2c_register_target_monitor_i (
    .link_clk(link_clk), .link_rst(link_rst), .scl(link_if.scl),
    .host_sda_o(link_if.host_sda_o), .host_sda_oe(link_if.host_sda_oe),
    .dev_sda_o(link_if.dev_sda_o), .dev_sda_oe(link_if.dev_sda_oe), .sda(link_if.sda));

  // Clocks
  always #10 clk = ~clk;
  // Link clock offset so its edges never meet the system clock's
  initial #0.7 forever #3 link_clk = ~link_clk;

  // Register file: combinational read, logged writes
  assign reg_rd_data = mem[reg_rd_addr];
  always @(posedge link_clk) begin
    if (reg_wr_valid === 1'b1) begin
      mem[reg_wr_addr] <= reg_wr_data;
      wlog.push_back({reg_wr_addr, reg_wr_data});
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask

  // One transaction; feeds write bytes and gathers read bytes
  task automatic xfer(input op_type op, input logic [6:0] a, input logic [7:0] off,
                      input logic [7:0] n);
    int k;
    rq = {};
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_offset <= off;
    cmd_len <= n;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    for (k = 0; k < 20000 && done !== 1'b1; k++) begin
      @(posedge clk);
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
        void'(wq.pop_front());
        wr_valid <= 1'b0;
      end else if (wr_ready === 1'b1 && wq.size() > 0) begin
        wr_valid <= 1'b1;
        wr_data <= wq[0];
      end
    end
    // Transfer never finished
    if (k == 20000) failures++;
  endtask

  task automatic check_reads(input logic [7:0] first, input int n);
    check(rq.size(), n);
    for (int i = 0; i < n && i < rq.size(); i++) check(rq[i], exp_mem[8'(first + i)]);
  endtask

  task automatic t_power_up();
    check(own_address, 7'h12);
    xfer(op_read_plain, 7'h12, 8'h00, 8'd3);
    check(nack_err, 1'b0);
    check_reads(8'h00, 3);
  endtask

  // Three-byte data write then four-byte combined read back from the same offset
  task automatic t_write_read();
    wlog = {};
    for (int i = 0; i < 3; i++) begin
      exp_mem[8'h0A + i] = 8'(8'h11 * (i + 1));
      wq.push_back(exp_mem[8'h0A + i]);
    end
    xfer(op_write, 7'h12, 8'h0A, 8'd3);
    check(wlog.size(), 3);
    for (int i = 0; i < 3; i++) check(wlog[i], {8'(8'h0A + i), exp_mem[8'h0A + i]});
    xfer(op_read_combined, 7'h12, 8'h0A, 8'd4);
    check_reads(8'h0A, 4);
  endtask

  // Offset only, then plain reads continue past a refused byte
  task automatic t_pointer_only();
    wlog = {};
    xfer(op_write, 7'h12, 8'h30, 8'd0);
    check(wlog.size(), 0);
    xfer(op_read_plain, 7'h12, 8'h00, 8'd2);
    check_reads(8'h30, 2);
    xfer(op_read_plain, 7'h12, 8'h00, 8'd1);
    check_reads(8'h32, 1);
  endtask

  task automatic t_wrong_target();
    wlog = {};
    wq = {8'h5A};
    xfer(op_write, 7'h13, 8'h40, 8'd1);
    check(nack_err, 1'b1);
    check(wlog.size(), 0);
    wq = {};
    xfer(op_read_plain, 7'h12, 8'h00, 8'd1);
    check_reads(8'h33, 1);
  endtask

  // Other strap levels, then floating again; each power-good reset clears the pointer
  task automatic t_strap_reset();
    strap_high <= LEVEL_LOW;
    strap_low  <= LEVEL_HIGH;
    link_rst   <= 1'b1;
    repeat (2) @(posedge clk);
    link_rst <= 1'b0;
    repeat (10) @(posedge clk);
    check(own_address, 7'h47);
    strap_high <= LEVEL_FLOAT;
    strap_low  <= LEVEL_FLOAT;
    link_rst   <= 1'b1;
    repeat (2) @(posedge clk);
    link_rst <= 1'b0;
    repeat (10) @(posedge clk);
    check(own_address, 7'h12);
    xfer(op_read_plain, 7'h12, 8'h00, 8'd1);
    check_reads(8'h00, 1);
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {clk, link_clk, rst, link_rst} = 4'hF;
    {cmd_valid, wr_valid, failures, cmp_count} = '0;
    {cmd_addr, cmd_offset, cmd_len, wr_data} = '0;
    cmd_op = op_write;
    {strap_high, strap_low} = {LEVEL_FLOAT, LEVEL_FLOAT};
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    exp_mem = mem;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    link_rst <= 1'b0;
    // Straps settle before traffic
    repeat (10) @(posedge clk);
    t_power_up();
    t_write_read();
    t_pointer_only();
    t_wrong_target();
    t_strap_reset();
    stop_test();
  end

  // Hang guard
  initial begin
    #1000000;
    failures++;
    stop_test();
  end
endmodule
